//--- frwl_row_writer.sv
`timescale 1ns/1ns
`include "frwl_defines.svh"
// Functional notes
// - starting a write never erases; erase acts on one whole row.
// - erase works on exactly one row at a time.
// - one program operation writes at most the 32 latches.
// - high<6:0> and low<7:5> pick row; low<4:0> picks latch.
// - writes stay inside one row, never spilling to neighbours.
// - all latches return to 0x3FFF after each write or erase.
// - latch-only select 1: unlock only loads the addressed latch.
// - latch-only select 0: unlock loads latch then programs whole row.
// - nothing but the error flag changes unless the unlock sequence completed uninterrupted.
// - unloaded latches stay blank; partial rows are accepted.
// - latch-only select is ignored while erase select is 1.
// - error flag is set by hardware whenever write start is set.
// - config space select redirects to user id and config region.
module frwl_row_writer (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [`FRWL_ADDR_HIGH_W-1:0] flash_addr_high_i,
    input wire logic [`FRWL_ADDR_LOW_W-1:0] flash_addr_low_i,
    input wire logic [`FRWL_DATA_HIGH_W-1:0] flash_data_high_i,
    input wire logic [`FRWL_DATA_LOW_W-1:0] flash_data_low_i,
    input wire logic program_enable_i,
    input wire logic config_space_select_i,
    input wire logic latch_only_select_i,
    input wire logic erase_select_i,
    input wire logic unlock_done_i,
    input wire logic unlock_abort_i,
    input wire logic error_clear_i,
    output logic write_busy_o,
    output logic program_error_flag_o,
    output logic flash_prog_o,
    output logic flash_erase_o,
    output logic flash_cfg_space_o,
    output logic [`FRWL_ROW_W-1:0] flash_row_o,
    output logic [`FRWL_NUM_LATCHES*`FRWL_WORD_W-1:0] flash_row_data_o
);
    localparam logic [`FRWL_CNT_W-1:0] PROG_CNT = `FRWL_CNT_W'(`FRWL_PROG_CYCLES);

    // sequencer state, latch bank and captured target
    frwl_pkg::frwl_state_t state_r;
    logic [`FRWL_WORD_W-1:0] latch_r [`FRWL_NUM_LATCHES];
    logic [`FRWL_CNT_W-1:0] cnt_r;
    logic [`FRWL_ROW_W-1:0] row_r;
    logic cfg_r;
    logic go;
    logic load_en;
    logic commit_en;
    logic erase_en;
    logic [`FRWL_ROW_W-1:0] row_sel;
    logic [`FRWL_IDX_W-1:0] idx_sel;
    logic [`FRWL_WORD_W-1:0] data_in;
    logic [`FRWL_CNT_W-1:0] prog_len_r;

    // address split into row and latch index
    // row and index split
    assign row_sel = {flash_addr_high_i, flash_addr_low_i[`FRWL_ADDR_LOW_W-1:`FRWL_ROW_LSB]};
    assign idx_sel = flash_addr_low_i[`FRWL_IDX_W-1:`FRWL_IDX_LSB];
    assign data_in = {flash_data_high_i, flash_data_low_i};

    // accepted unlock; an aborted unlock starts nothing and loads no latch
    // unlock gating
    assign go = unlock_done_i && !unlock_abort_i && program_enable_i
        && (state_r == frwl_pkg::FRWL_IDLE);
    assign erase_en = go && erase_select_i;
    assign load_en = go && !erase_select_i;
    assign commit_en = go && !erase_select_i && !latch_only_select_i;

    // operation sequencer, self timed
    // busy until one cycle after timer ends
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= frwl_pkg::FRWL_IDLE;
            cnt_r <= '0;
        end else begin
            case (state_r)
                frwl_pkg::FRWL_IDLE: begin
                    cnt_r <= PROG_CNT;
                    if (erase_en) begin
                        state_r <= frwl_pkg::FRWL_ERASE;
                    end else if (commit_en) begin
                        state_r <= frwl_pkg::FRWL_PROG;
                    end
                end
                frwl_pkg::FRWL_PROG, frwl_pkg::FRWL_ERASE: begin
                    cnt_r <= cnt_r - 1'b1;
                    if (cnt_r == `FRWL_CNT_W'(1)) begin
                        state_r <= frwl_pkg::FRWL_DONE;
                    end
                end
                frwl_pkg::FRWL_DONE: begin
                    state_r <= frwl_pkg::FRWL_IDLE;
                end
                default: begin
                    state_r <= frwl_pkg::FRWL_IDLE;
                end
            endcase
        end
    end

    // row and space captured at start, held through operation
    // one row erase
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            row_r <= '0;
            cfg_r <= 1'b0;
        end else if (erase_en || commit_en) begin
            row_r <= row_sel;
            cfg_r <= config_space_select_i;
        end
    end

    // write latches, one per word of the row
    // 32 latches
    genvar gi;
    generate
        for (gi = 0; gi < `FRWL_NUM_LATCHES; gi++) begin : g_latch
            always_ff @(posedge ref_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    latch_r[gi] <= `FRWL_BLANK_WORD;
                end else if (state_r == frwl_pkg::FRWL_DONE) begin
                    latch_r[gi] <= `FRWL_BLANK_WORD;
                end else if (load_en && idx_sel == `FRWL_IDX_W'(gi)) begin
                    latch_r[gi] <= data_in;
                end
            end
            assign flash_row_data_o[gi*`FRWL_WORD_W +: `FRWL_WORD_W] = latch_r[gi];
        end
    endgenerate

    // error flag: set on every start, set beats clear
    // hardware sets error flag
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            program_error_flag_o <= 1'b0;
        end else if (unlock_done_i && program_enable_i) begin
            program_error_flag_o <= 1'b1;
        end else if (error_clear_i) begin
            program_error_flag_o <= 1'b0;
        end
    end

    // length of the current program or erase window, read by the checks only
    // window length count
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prog_len_r <= '0;
        end else if (flash_prog_o || flash_erase_o) begin
            prog_len_r <= prog_len_r + 1'b1;
        end else begin
            prog_len_r <= '0;
        end
    end

    // status and flash strobes
    assign write_busy_o = (state_r != frwl_pkg::FRWL_IDLE);
    assign flash_prog_o = (state_r == frwl_pkg::FRWL_PROG);
    assign flash_erase_o = (state_r == frwl_pkg::FRWL_ERASE);
    assign flash_cfg_space_o = cfg_r;
    assign flash_row_o = row_r;

    // checks on request decoding
    a_latch_only_load: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (go && latch_only_select_i && !erase_select_i) |=> (state_r == frwl_pkg::FRWL_IDLE))
        else $error("latch-only load started an operation");
    a_commit_starts: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        commit_en |=> flash_prog_o)
        else $error("commit did not start programming");
    a_latch_loaded: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        load_en |=> latch_r[$past(idx_sel)] == $past(data_in))
        else $error("addressed latch not loaded");
    a_abort_blocks: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (unlock_abort_i && state_r == frwl_pkg::FRWL_IDLE) |=> !write_busy_o)
        else $error("aborted unlock started an operation");
    a_erase_wins: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        erase_en |=> flash_erase_o && !flash_prog_o)
        else $error("erase select did not override latch-only");

    // checks on the latch bank and the error flag
    a_erase_no_load: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        erase_en |=> $stable(flash_row_data_o))
        else $error("erase request changed a latch");
    a_busy_refused: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (unlock_done_i && (flash_prog_o || flash_erase_o)) |=> $stable(flash_row_data_o))
        else $error("request during an operation changed a latch");
    a_blank_after: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (state_r == frwl_pkg::FRWL_DONE) |=> latch_r[0] == `FRWL_BLANK_WORD
        && latch_r[`FRWL_NUM_LATCHES-1] == `FRWL_BLANK_WORD)
        else $error("latches not blank after completion");
    a_error_set: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (unlock_done_i && program_enable_i) |=> program_error_flag_o)
        else $error("error flag not set on start");

    // checks on the operation window
    a_row_stable: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (flash_prog_o && $past(flash_prog_o)) |-> $stable(flash_row_o))
        else $error("row changed during write");
    a_busy_len: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        $rose(flash_prog_o) |-> flash_prog_o [*8])
        else $error("program ended too early");
    a_op_length: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (state_r == frwl_pkg::FRWL_DONE) |-> (prog_len_r == PROG_CNT))
        else $error("operation window length differs from the timer setting");

    // cover points for the main scenarios
    c_load: cover property (@(posedge ref_clk_i) load_en && latch_only_select_i);
    c_commit: cover property (@(posedge ref_clk_i) commit_en);
    c_erase: cover property (@(posedge ref_clk_i) erase_en);
    c_abort: cover property (@(posedge ref_clk_i) unlock_done_i && unlock_abort_i);
    c_refused: cover property (@(posedge ref_clk_i) unlock_done_i && write_busy_o);
endmodule

//--- frwl_defines.svh
`ifndef FRWL_DEFINES_SVH
`define FRWL_DEFINES_SVH
`define FRWL_NUM_LATCHES 32
`define FRWL_WORD_W 14
`define FRWL_BLANK_WORD 14'h3FFF
`define FRWL_ROW_W 10
`define FRWL_IDX_W 5
`define FRWL_IDX_LSB 0
`define FRWL_ROW_LSB 5
`define FRWL_ADDR_HIGH_W 7
`define FRWL_ADDR_LOW_W 8
`define FRWL_DATA_HIGH_W 6
`define FRWL_DATA_LOW_W 8
`define FRWL_PROG_TIME_NS 2000
`define FRWL_CLK_PERIOD_NS 10
`define FRWL_PROG_CYCLES ((`FRWL_PROG_TIME_NS + `FRWL_CLK_PERIOD_NS - 1) / `FRWL_CLK_PERIOD_NS)
`define FRWL_CNT_W 12
`endif

//--- frwl_pkg.sv
package frwl_pkg;
    typedef enum logic [1:0] {
        FRWL_IDLE = 2'b00,
        FRWL_PROG = 2'b01,
        FRWL_ERASE = 2'b10,
        FRWL_DONE = 2'b11
    } frwl_state_t;
endpackage

//--- flash_row_write_latches_bench.sv
`timescale 1ns/1ns
`include "frwl_defines.svh"
module flash_row_write_latches_bench;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [`FRWL_ADDR_HIGH_W-1:0] ah = 7'h55;
    logic [`FRWL_ADDR_LOW_W-1:0] al = 8'h00;
    logic [`FRWL_DATA_HIGH_W-1:0] dh = 6'h00;
    logic [`FRWL_DATA_LOW_W-1:0] dl = 8'h00;
    logic en = 1'b1, cfg = 1'b0, lo = 1'b0, er = 1'b0, go = 1'b0, ab = 1'b0, clr = 1'b0;
    logic busy, err, prog, ers, cfg_o;
    logic [9:0] row;
    logic [447:0] rdata;
    logic [447:0] exp_row = {32{14'h3FFF}};
    int mismatches = 0;
    int comparisons = 0;
    // 100 MHz clock
    always #5 ref_clk_i = ~ref_clk_i;
    frwl_row_writer dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .flash_addr_high_i(ah),
        .flash_addr_low_i(al), .flash_data_high_i(dh), .flash_data_low_i(dl),
        .program_enable_i(en), .config_space_select_i(cfg), .latch_only_select_i(lo),
        .erase_select_i(er), .unlock_done_i(go), .unlock_abort_i(ab), .error_clear_i(clr),
        .write_busy_o(busy), .program_error_flag_o(err), .flash_prog_o(prog),
        .flash_erase_o(ers), .flash_cfg_space_o(cfg_o), .flash_row_o(row),
        .flash_row_data_o(rdata));
    // flag and vector comparisons
    task chk_bit(input string name, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %b seen %b", name, e, g);
        end
    endtask
    task chk_vec(input string name, input logic [447:0] e, input logic [447:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, e, g);
        end
    endtask
    // one unlock pulse, then one settling cycle
    task unlock(input logic [7:0] low, input logic [13:0] d, input logic l, input logic e,
        input logic a);
        al = low;
        {dh, dl} = d;
        lo = l;
        er = e;
        ab = a;
        go = 1'b1;
        @(negedge ref_clk_i);
        go = 1'b0;
        ab = 1'b0;
        @(negedge ref_clk_i);
    endtask
    task wait_idle;
        for (int n = 0; n < 400 && busy !== 1'b0; n++) @(negedge ref_clk_i);
        chk_bit("idle", 1'b0, busy);
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // watchdog
    initial begin
        #50000;
        mismatches++;
        $display("unexpected watchdog expected idle seen hang");
        report_and_stop();
    end
    // main sequence
    initial begin
        repeat (5) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        chk_vec("latches", exp_row, rdata);
        chk_bit("busy", 1'b0, busy);
        unlock(8'hBF, 14'h1234, 1'b1, 1'b0, 1'b0);
        exp_row[31*14+:14] = 14'h1234;
        chk_vec("latches", exp_row, rdata);
        chk_bit("prog", 1'b0, prog);
        chk_bit("busy", 1'b0, busy);
        chk_bit("err", 1'b1, err);
        clr = 1'b1;
        @(negedge ref_clk_i);
        clr = 1'b0;
        @(negedge ref_clk_i);
        chk_bit("err", 1'b0, err);
        unlock(8'hA1, 14'h0AAA, 1'b1, 1'b0, 1'b1);
        chk_vec("latches", exp_row, rdata);
        en = 1'b0;
        unlock(8'hA2, 14'h0BBB, 1'b1, 1'b0, 1'b0);
        chk_vec("latches", exp_row, rdata);
        en = 1'b1;
        unlock(8'hA0, 14'h2222, 1'b0, 1'b0, 1'b0);
        exp_row[13:0] = 14'h2222;
        chk_vec("latches", exp_row, rdata);
        chk_bit("prog", 1'b1, prog);
        chk_bit("erase", 1'b0, ers);
        chk_bit("busy", 1'b1, busy);
        chk_bit("err", 1'b1, err);
        chk_vec("row", 448'({7'h55, 3'h5}), 448'(row));
        unlock(8'hA3, 14'h0CCC, 1'b1, 1'b0, 1'b0);
        chk_vec("latches", exp_row, rdata);
        wait_idle();
        exp_row = {32{14'h3FFF}};
        chk_vec("latches", exp_row, rdata);
        chk_bit("prog", 1'b0, prog);
        // partial row: latch-only loads with a rising address, then the commit
        unlock(8'h40, 14'h0111, 1'b1, 1'b0, 1'b0);
        unlock(8'h41, 14'h0222, 1'b1, 1'b0, 1'b0);
        unlock(8'h42, 14'h0333, 1'b0, 1'b0, 1'b0);
        exp_row[13:0] = 14'h0111;
        exp_row[27:14] = 14'h0222;
        exp_row[41:28] = 14'h0333;
        chk_vec("latches", exp_row, rdata);
        chk_bit("prog", 1'b1, prog);
        chk_bit("cfg", 1'b0, cfg_o);
        chk_vec("row", 448'({7'h55, 3'h2}), 448'(row));
        wait_idle();
        exp_row = {32{14'h3FFF}};
        chk_vec("latches", exp_row, rdata);
        // a loaded latch survives the erase request and is blanked after it
        unlock(8'hA5, 14'h0EEE, 1'b1, 1'b0, 1'b0);
        exp_row[5*14+:14] = 14'h0EEE;
        cfg = 1'b1;
        unlock(8'hA4, 14'h0DDD, 1'b1, 1'b1, 1'b0);
        chk_bit("erase", 1'b1, ers);
        chk_bit("prog", 1'b0, prog);
        chk_bit("cfg", 1'b1, cfg_o);
        chk_vec("row", 448'({7'h55, 3'h5}), 448'(row));
        chk_vec("latches", exp_row, rdata);
        wait_idle();
        exp_row = {32{14'h3FFF}};
        chk_bit("erase", 1'b0, ers);
        chk_vec("latches", exp_row, rdata);
        // reset in the middle of a row write, then a fresh load
        cfg = 1'b0;
        unlock(8'hE7, 14'h3001, 1'b0, 1'b0, 1'b0);
        repeat (20) @(negedge ref_clk_i);
        chk_bit("prog", 1'b1, prog);
        nrst_i = 1'b0;
        @(negedge ref_clk_i);
        chk_bit("busy", 1'b0, busy);
        chk_bit("err", 1'b0, err);
        chk_vec("latches", exp_row, rdata);
        nrst_i = 1'b1;
        @(negedge ref_clk_i);
        unlock(8'hE8, 14'h3002, 1'b1, 1'b0, 1'b0);
        exp_row[8*14+:14] = 14'h3002;
        chk_vec("latches", exp_row, rdata);
        chk_bit("busy", 1'b0, busy);
        report_and_stop();
    end
endmodule
